// [design/serial_if_regs_pkg.sv]
`default_nettype none
package serial_if_regs_pkg;

  // ------------------------------------------------------------
  // Bus and register geometry
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned IDX_W  = 12;
  localparam int unsigned SER_W  = 10;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_WAKE       = 12'h603;
  localparam logic [11:0] IDX_CTRL_ONE   = 12'h608;
  localparam logic [11:0] IDX_LPI_TMR    = 12'h609;
  localparam logic [11:0] IDX_STATUS     = 12'h60a;
  localparam logic [11:0] IDX_INT_STATUS = 12'h610;
  localparam logic [11:0] IDX_INT_MASK   = 12'h611;

  // Reset values and writable-bit masks
  localparam logic [15:0] RST_WAKE     = 16'h0000;
  localparam logic [15:0] RST_CTRL_ONE = 16'h007b;
  localparam logic [15:0] RST_LPI_TMR  = 16'h0000;
  localparam logic [15:0] WR_MASK_WAKE = 16'h0003;
  localparam logic [15:0] WR_MASK_INT  = 16'h0003;

  // Status and interrupt bit positions
  localparam int unsigned ST_PAGE_BIT  = 12;
  localparam int unsigned ST_ANDONE_BIT = 10;
  localparam int unsigned INT_PAGE_BIT = 0;
  localparam int unsigned INT_DONE_BIT = 1;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned AN_T0_NS      = 1600000;
  localparam int unsigned AN_T1_NS      = 2000;
  localparam int unsigned AN_T2_NS      = 800000;
  localparam int unsigned AN_T3_NS      = 11000000;
  localparam int unsigned AN_T0_CYC     = AN_T0_NS / CLK_PERIOD_NS;
  localparam int unsigned AN_T1_CYC     = AN_T1_NS / CLK_PERIOD_NS;
  localparam int unsigned AN_T2_CYC     = AN_T2_NS / CLK_PERIOD_NS;
  localparam int unsigned AN_T3_CYC     = AN_T3_NS / CLK_PERIOD_NS;
  localparam int unsigned AN_CNT_W      = 17;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       tx_err_dis;
    logic       align_force;
    logic [3:0] align_idx;
    logic       serial_en;
    logic       rx_pol_inv;
    logic       tx_pol_inv;
    logic [1:0] tx_bits_order;
    logic       rx_bits_order;
    logic       pkt_align;
    logic [1:0] an_timer;
    logic       an_en;
  } ctrl_one_s;

  typedef struct packed {
    logic [4:0] tx_lpi_refresh_time;
    logic [4:0] tx_lpi_quiet_time;
    logic [4:0] tx_lpi_sleep_time;
    logic       non_eee_compat;
  } lpi_tmr_s;

  typedef enum logic [1:0] {AN_OFF, AN_TIMING, AN_DONE} an_state_e;

endpackage : serial_if_regs_pkg
`default_nettype wire

// [design/serial_if_regs.sv]
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none
module serial_if_regs #(
  parameter logic [3:0]  IDLE_CODE = 4'h1,  // Idle indication on receive data
  parameter int unsigned AN_CYC_0  = serial_if_regs_pkg::AN_T0_CYC,
  parameter int unsigned AN_CYC_2  = serial_if_regs_pkg::AN_T2_CYC,
  parameter int unsigned AN_CYC_3  = serial_if_regs_pkg::AN_T3_CYC
) (
  input  wire  logic        REF_CLK,             // 10 MHz clock
  input  wire  logic        RST_N,               // Async reset, active low
  input  wire  logic        HSEL,                // Slave select
  input  wire  logic [31:0] HADDR,               // Byte address
  input  wire  logic [1:0]  HTRANS,              // Transfer type
  input  wire  logic        HWRITE,              // Write when high
  input  wire  logic [2:0]  HSIZE,               // Word only
  input  wire  logic [31:0] HWDATA,              // Write data
  input  wire  logic        HREADY,              // Bus ready
  output logic        [31:0] HRDATA,             // Read data
  output logic               HREADYOUT,          // Always ready
  output logic               HRESP,              // Always OKAY
  input  wire  logic        STRAP_BIT_ZERO,      // Receive-data strap 0
  input  wire  logic        STRAP_BIT_ONE,       // Receive-data strap 1
  input  wire  logic        STRAP_BIT_TWO,       // Receive-data strap 2
  input  wire  logic        LPI_IDLE,            // Receive path in low-power idle
  input  wire  logic        LPI_EXIT,            // Receive path leaving idle
  input  wire  logic        RX_CTRL_IN,          // Normal rx control
  input  wire  logic [3:0]  RXD_IN,              // Normal rx data
  output logic               RX_CTRL_OUT,        // Rx control to MAC
  output logic        [3:0]  RXD_OUT,            // Rx data to MAC
  input  wire  logic        TX_ERR_IN,           // Transmit error from MAC
  output logic               TX_ERR_OUT,         // Transmit error to core
  input  wire  logic [3:0]  ALIGN_IDX_FOUND,     // Index from alignment logic
  output logic        [3:0]  ALIGN_IDX_SEL,      // Index in use
  input  wire  logic [9:0]  SER_RX_WORD,         // From deserializer
  output logic        [9:0]  CORE_RX_WORD,       // Into decoder
  input  wire  logic [9:0]  CORE_TX_WORD,        // From encoder
  output logic        [9:0]  SER_TX_WORD,        // Toward serializer
  input  wire  logic        TX_PKT_START_REQ,    // Packet ready to read out
  input  wire  logic        TX_EVEN,             // Even code-group slot pulse
  output logic               TX_PKT_START,       // Packet read-out start
  input  wire  logic        AN_RESTART,          // Restart autoneg pulse
  input  wire  logic        AN_LINK_OK,          // Partner exchange good
  input  wire  logic        AN_PAGE_RX,          // New page pulse
  output logic               SERIAL_EN,          // Serial interface enabled
  output logic               AN_ENABLE,          // Autoneg enabled
  output logic               AN_COMPLETE,        // Autoneg completed
  output logic               NON_EEE_COMPAT,     // Non-EEE MAC support
  output logic        [4:0]  TX_LPI_REFRESH_TIME, // Refresh timer setting
  output logic        [4:0]  TX_LPI_QUIET_TIME,  // Quiet timer setting
  output logic        [4:0]  TX_LPI_SLEEP_TIME,  // Sleep timer setting
  output logic               IRQ                 // Level interrupt
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  serial_if_regs_pkg::ctrl_one_s ctrl_q;
  serial_if_regs_pkg::lpi_tmr_s  lpi_q;
  serial_if_regs_pkg::an_state_e an_state_q;
  logic [1:0]  wake_q;
  logic [1:0]  int_st_q;
  logic [1:0]  int_mask_q;
  logic        wr_q;
  logic [11:0] widx_q;
  logic        init_q;
  logic        page_q;
  logic        pend_q;
  logic [16:0] an_cnt_q;
  logic        an_done_q;

  // Address phase accepted when selected, active and bus ready
  wire         acc_v   = HSEL & HTRANS[1] & HREADY;
  wire         addr_ok = (HADDR[31:14] == 18'h00000) & (HADDR[1:0] == 2'b00);
  wire  [11:0] a_idx   = HADDR[13:2];
  wire         rd_v    = acc_v & ~HWRITE & addr_ok;
  wire         wr_v    = acc_v & HWRITE & addr_ok;
  wire         st_rd   = rd_v & (a_idx == serial_if_regs_pkg::IDX_STATUS);
  wire  [15:0] wdat    = HWDATA[15:0];
  wire         w_wake  = wr_q & (widx_q == serial_if_regs_pkg::IDX_WAKE);
  wire         w_ctrl  = wr_q & (widx_q == serial_if_regs_pkg::IDX_CTRL_ONE);
  wire         w_lpi   = wr_q & (widx_q == serial_if_regs_pkg::IDX_LPI_TMR);
  wire         w_ist   = wr_q & (widx_q == serial_if_regs_pkg::IDX_INT_STATUS);
  wire         w_imask = wr_q & (widx_q == serial_if_regs_pkg::IDX_INT_MASK);

  // Read mux; reserved and unmapped bits read zero
  wire  [15:0] status_v = 16'((32'(page_q) << serial_if_regs_pkg::ST_PAGE_BIT)
                        | (32'(an_done_q) << serial_if_regs_pkg::ST_ANDONE_BIT));
  wire  [15:0] rd_mux =
      (a_idx == serial_if_regs_pkg::IDX_WAKE)       ? {14'h0000, wake_q} :
      (a_idx == serial_if_regs_pkg::IDX_CTRL_ONE)   ? 16'(ctrl_q) :
      (a_idx == serial_if_regs_pkg::IDX_LPI_TMR)    ? 16'(lpi_q) :
      (a_idx == serial_if_regs_pkg::IDX_STATUS)     ? status_v :
      (a_idx == serial_if_regs_pkg::IDX_INT_STATUS) ? {14'h0000, int_st_q} :
      (a_idx == serial_if_regs_pkg::IDX_INT_MASK)   ? {14'h0000, int_mask_q} :
                                                      16'h0000;

  // Zero-wait slave; read data captured at the address phase edge
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_q      <= 1'b0;
      widx_q    <= 12'h000;
    end
    else
    begin
      HRDATA    <= rd_v ? {16'h0000, rd_mux} : 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_q      <= wr_v;
      widx_q    <= a_idx;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Straps are caught on the first edge after release, not by reset itself
  wire strap_en = ~(STRAP_BIT_TWO | STRAP_BIT_ONE | STRAP_BIT_ZERO);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      init_q <= 1'b0;
      ctrl_q <= serial_if_regs_pkg::ctrl_one_s'(serial_if_regs_pkg::RST_CTRL_ONE);
      lpi_q  <= serial_if_regs_pkg::lpi_tmr_s'(serial_if_regs_pkg::RST_LPI_TMR);
      wake_q <= serial_if_regs_pkg::RST_WAKE[1:0];
    end
    else
    begin
      init_q <= 1'b1;
      if (!init_q)
        ctrl_q.serial_en <= strap_en;
      else if (w_ctrl)
        ctrl_q <= serial_if_regs_pkg::ctrl_one_s'(wdat);
      if (w_lpi)
        lpi_q <= serial_if_regs_pkg::lpi_tmr_s'(wdat);
      if (w_wake)
        wake_q <= wdat[1:0];
    end
  end

  // ------------------------------------------------------------
  // Parallel interface wake signalling
  // ------------------------------------------------------------
  // A 00 wake code is not protected against; bit meanings apply as written
  wire       rx_ctrl_d = LPI_EXIT ? wake_q[1] : (LPI_IDLE ? 1'b0 : RX_CTRL_IN);
  wire [3:0] exit_rxd  = wake_q[0] ? 4'h0 : IDLE_CODE;
  wire [3:0] rxd_d     = LPI_EXIT ? exit_rxd : (LPI_IDLE ? IDLE_CODE : RXD_IN);

  // ------------------------------------------------------------
  // Serial datapath
  // ------------------------------------------------------------
  wire [9:0] rx_pol = SER_RX_WORD ^ {10{ctrl_q.rx_pol_inv}};
  logic [9:0] rx_rev;
  logic [9:0] tx_rev;

  // Bit reversal, one wire per bit
  for (genvar i = 0; i < 10; i++)
  begin : g_rev
    assign rx_rev[i] = rx_pol[9 - i];
    assign tx_rev[i] = CORE_TX_WORD[9 - i];
  end

  // Low bit of the order field picks reversed order into the core
  wire [9:0] rx_ord = ctrl_q.tx_bits_order[0] ? rx_rev : rx_pol;
  wire [9:0] tx_ord = ctrl_q.rx_bits_order ? tx_rev : CORE_TX_WORD;
  wire [9:0] tx_out = tx_ord ^ {10{ctrl_q.tx_pol_inv}};
  wire [3:0] idx_d  = ctrl_q.align_force ? ctrl_q.align_idx : ALIGN_IDX_FOUND;
  wire       en     = ctrl_q.serial_en;

  // Packet start waits for even slot; pending held across odd slots
  wire req_any   = pend_q | TX_PKT_START_REQ;
  wire pkt_go_d  = ctrl_q.pkt_align ? (req_any & TX_EVEN) : TX_PKT_START_REQ;
  wire pend_d    = ctrl_q.pkt_align & req_any & ~TX_EVEN;

  // ------------------------------------------------------------
  // Serial autonegotiation
  // ------------------------------------------------------------
  wire        an_go    = en & ctrl_q.an_en;
  wire [16:0] an_limit =
      (ctrl_q.an_timer == 2'd0) ? 17'(AN_CYC_0) :
      (ctrl_q.an_timer == 2'd1) ? 17'(serial_if_regs_pkg::AN_T1_CYC) :
      (ctrl_q.an_timer == 2'd2) ? 17'(AN_CYC_2) :
                                  17'(AN_CYC_3);
  wire        an_tick  = (an_cnt_q == an_limit - 17'd1);
  serial_if_regs_pkg::an_state_e an_state_d;
  logic [16:0] an_cnt_d;

  // Timer expiry with a good partner exchange completes; otherwise retry
  always_comb
  begin
    an_state_d = an_state_q;
    an_cnt_d   = an_cnt_q + 17'd1;
    unique case (an_state_q)
      serial_if_regs_pkg::AN_OFF:
      begin
        an_cnt_d = 17'd0;
        if (an_go)
          an_state_d = serial_if_regs_pkg::AN_TIMING;
      end
      serial_if_regs_pkg::AN_TIMING:
      begin
        if (!an_go)
          an_state_d = serial_if_regs_pkg::AN_OFF;
        else if (AN_RESTART)
          an_cnt_d = 17'd0;
        else if (an_tick)
        begin
          an_cnt_d = 17'd0;
          if (AN_LINK_OK)
            an_state_d = serial_if_regs_pkg::AN_DONE;
        end
      end
      serial_if_regs_pkg::AN_DONE:
      begin
        an_cnt_d = 17'd0;
        if (!an_go)
          an_state_d = serial_if_regs_pkg::AN_OFF;
        else if (AN_RESTART)
          an_state_d = serial_if_regs_pkg::AN_TIMING;
      end
    endcase
  end

  // Page flag: a new page in the clearing read cycle is kept
  wire page_d  = (AN_PAGE_RX & en) | (page_q & ~st_rd);
  wire done_d  = (an_state_d == serial_if_regs_pkg::AN_DONE);

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  wire [1:0] ev_v   = {done_d & ~an_done_q, AN_PAGE_RX & en};
  wire [1:0] int_d  = ev_v | (int_st_q & ~(w_ist ? wdat[1:0] : 2'b00));

  // State, status and registered outputs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      an_state_q <= serial_if_regs_pkg::AN_OFF;
      an_cnt_q   <= 17'd0;
      an_done_q  <= 1'b0;
      page_q     <= 1'b0;
      pend_q     <= 1'b0;
      int_st_q   <= 2'b00;
      int_mask_q <= 2'b00;
      IRQ        <= 1'b0;
    end
    else
    begin
      an_state_q <= an_state_d;
      an_cnt_q   <= an_cnt_d;
      an_done_q  <= done_d;
      page_q     <= page_d;
      pend_q     <= pend_d;
      int_st_q   <= int_d;
      int_mask_q <= w_imask ? (wdat[1:0] & serial_if_regs_pkg::WR_MASK_INT[1:0]) : int_mask_q;
      IRQ        <= |(int_st_q & int_mask_q);
    end
  end

  // Data-facing outputs, one register stage; serial words, transmit error and packet start zero when off
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RX_CTRL_OUT    <= 1'b0;
      RXD_OUT        <= 4'h0;
      TX_ERR_OUT     <= 1'b0;
      ALIGN_IDX_SEL  <= 4'h0;
      CORE_RX_WORD   <= 10'h000;
      SER_TX_WORD    <= 10'h000;
      TX_PKT_START   <= 1'b0;
      SERIAL_EN      <= 1'b0;
      AN_ENABLE      <= 1'b0;
      AN_COMPLETE    <= 1'b0;
      NON_EEE_COMPAT <= 1'b0;
      TX_LPI_REFRESH_TIME <= 5'h00;
      TX_LPI_QUIET_TIME   <= 5'h00;
      TX_LPI_SLEEP_TIME   <= 5'h00;
    end
    else
    begin
      RX_CTRL_OUT    <= rx_ctrl_d;
      RXD_OUT        <= rxd_d;
      TX_ERR_OUT     <= en & TX_ERR_IN & ~ctrl_q.tx_err_dis;
      ALIGN_IDX_SEL  <= idx_d;
      CORE_RX_WORD   <= en ? rx_ord : 10'h000;
      SER_TX_WORD    <= en ? tx_out : 10'h000;
      TX_PKT_START   <= en & pkt_go_d;
      SERIAL_EN      <= en;
      AN_ENABLE      <= ctrl_q.an_en;
      AN_COMPLETE    <= an_done_q;
      NON_EEE_COMPAT <= lpi_q.non_eee_compat;
      TX_LPI_REFRESH_TIME <= lpi_q.tx_lpi_refresh_time;
      TX_LPI_QUIET_TIME   <= lpi_q.tx_lpi_quiet_time;
      TX_LPI_SLEEP_TIME   <= lpi_q.tx_lpi_sleep_time;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_exit_ctrl;
    @(posedge REF_CLK) disable iff (!RST_N)
    (LPI_EXIT && wake_q[1]) |=> RX_CTRL_OUT;
  endproperty
  a_exit_ctrl: assert property (p_exit_ctrl)
    else $error("rx control not asserted during idle exit");

  property p_exit_rxd;
    @(posedge REF_CLK) disable iff (!RST_N)
    (LPI_EXIT && !wake_q[0]) |=> (RXD_OUT == IDLE_CODE);
  endproperty
  a_exit_rxd: assert property (p_exit_rxd)
    else $error("rx data not idle code during exit");

  property p_tx_err;
    @(posedge REF_CLK) disable iff (!RST_N)
    TX_ERR_OUT |-> $past(TX_ERR_IN) && !$past(ctrl_q.tx_err_dis) && SERIAL_EN;
  endproperty
  a_tx_err: assert property (p_tx_err)
    else $error("transmit error passed while disabled");

  property p_force_idx;
    @(posedge REF_CLK) disable iff (!RST_N)
    ctrl_q.align_force ##1 $stable(ctrl_q) |-> (ALIGN_IDX_SEL == ctrl_q.align_idx);
  endproperty
  a_force_idx: assert property (p_force_idx)
    else $error("forced word index not used");

  property p_strap;
    @(posedge REF_CLK) disable iff (!RST_N)
    (init_q && !$past(init_q)) |-> (ctrl_q.serial_en == $past(strap_en));
  endproperty
  a_strap: assert property (p_strap)
    else $error("serial enable not taken from straps");

  property p_pkt_even;
    @(posedge REF_CLK) disable iff (!RST_N)
    (TX_PKT_START && $past(ctrl_q.pkt_align)) |-> $past(TX_EVEN);
  endproperty
  a_pkt_even: assert property (p_pkt_even)
    else $error("packet start off the even slot");

  property p_an_time;
    @(posedge REF_CLK) disable iff (!RST_N)
    (an_state_q == serial_if_regs_pkg::AN_TIMING && an_go && !AN_RESTART
      && an_tick && AN_LINK_OK) |=> an_done_q ##1 AN_COMPLETE;
  endproperty
  a_an_time: assert property (p_an_time)
    else $error("autoneg did not complete at timer expiry");

  property p_page_keep;
    @(posedge REF_CLK) disable iff (!RST_N)
    (AN_PAGE_RX && en) |=> page_q;
  endproperty
  a_page_keep: assert property (p_page_keep)
    else $error("page flag lost");

  property p_rsvd;
    @(posedge REF_CLK) disable iff (!RST_N)
    HRDATA[31:16] == 16'h0000 && HRDATA[15:2] == 14'h0000 || !$past(rd_v)
      || $past(a_idx) != serial_if_regs_pkg::IDX_WAKE;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");

endmodule : serial_if_regs
`default_nettype wire

// [verif/mac_far_model.sv]
`default_nettype none
// ------------------------------------------------------------
// MAC side and line side stimulus source
// ------------------------------------------------------------
module mac_far_model (
  input  wire logic       clk,       // Bench clock
  input  wire logic       step,      // Draw a fresh set of values
  output logic            tx_err,    // Transmit error from the MAC
  output logic            rx_ctrl,   // Normal receive control
  output logic [3:0]      rxd,       // Normal receive data
  output logic [3:0]      idx_found, // Boundary index found by alignment
  output logic [9:0]      ser_rx,    // Deserialized receive word
  output logic [9:0]      core_tx    // Encoded transmit word
);
  timeunit 1ns;
  timeprecision 1ns;

  // Values move only on request, so the bench can predict every output
  initial {tx_err, rx_ctrl, rxd, idx_found, ser_rx, core_tx} = '0;

  // A held value would hide a stuck path, so each step draws new bits
  always @(posedge clk)
    if (step)
    begin
      {tx_err, rx_ctrl, rxd, idx_found, ser_rx, core_tx} <= 30'($urandom);
    end
endmodule : mac_far_model
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [31:0] e;} note_s;
  // ------------------------------------------------------------
  // Signals mirror the block's port names
  // ------------------------------------------------------------
  logic              REF_CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic              strap = 1'b0, LPI_EXIT = 1'b0, AN_LINK_OK = 1'b0, AN_PAGE_RX = 1'b0;
  logic              step = 1'b0, rd_ph = 1'b0, smp = 1'b0, LPI_IDLE = 1'b0;
  logic              TX_PKT_START_REQ = 1'b0, TX_EVEN = 1'b0;
  logic [1:0]        HTRANS = '0, pk;
  logic [2:0]        psel = '0;
  logic [31:0]       HADDR = '0, HWDATA = '0, HRDATA, r;
  logic              HREADYOUT, HRESP, RX_CTRL_OUT, TX_ERR_OUT, TX_PKT_START, SERIAL_EN;
  logic              AN_ENABLE, AN_COMPLETE, NON_EEE_COMPAT, IRQ, TX_ERR_IN, RX_CTRL_IN;
  logic [3:0]        RXD_OUT, ALIGN_IDX_SEL, RXD_IN, ALIGN_IDX_FOUND;
  logic [4:0]        TX_LPI_REFRESH_TIME, TX_LPI_QUIET_TIME, TX_LPI_SLEEP_TIME;
  logic [9:0]        CORE_RX_WORD, SER_TX_WORD, SER_RX_WORD, CORE_TX_WORD;
  logic [5:0][31:0]  pv;
  note_s             q[$], n;
  int                fails = 0, n_compared = 0, k;
  int                lim[4] = '{30, 20, 25, 40};

  always #50 REF_CLK = ~REF_CLK;

  serial_if_regs #(.AN_CYC_0(30), .AN_CYC_2(25), .AN_CYC_3(40)) serial_if_regs_inst (
    .REF_CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'b010), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .STRAP_BIT_ZERO(strap),
    .STRAP_BIT_ONE(strap), .STRAP_BIT_TWO(strap), .LPI_IDLE, .LPI_EXIT, .RX_CTRL_IN,
    .RXD_IN, .RX_CTRL_OUT, .RXD_OUT, .TX_ERR_IN, .TX_ERR_OUT, .ALIGN_IDX_FOUND,
    .ALIGN_IDX_SEL, .SER_RX_WORD, .CORE_RX_WORD, .CORE_TX_WORD, .SER_TX_WORD,
    .TX_PKT_START_REQ, .TX_EVEN, .TX_PKT_START, .AN_RESTART(1'b0), .AN_LINK_OK,
    .AN_PAGE_RX, .SERIAL_EN, .AN_ENABLE, .AN_COMPLETE, .NON_EEE_COMPAT, .TX_LPI_REFRESH_TIME,
    .TX_LPI_QUIET_TIME, .TX_LPI_SLEEP_TIME, .IRQ);

  mac_far_model mac_far_model_inst (
    .clk(REF_CLK), .step, .tx_err(TX_ERR_IN), .rx_ctrl(RX_CTRL_IN), .rxd(RXD_IN),
    .idx_found(ALIGN_IDX_FOUND), .ser_rx(SER_RX_WORD), .core_tx(CORE_TX_WORD));

  // Port groups that a probe note can select
  assign pv[0] = 32'({RX_CTRL_OUT, RXD_OUT});
  assign pv[1] = 32'({TX_PKT_START, TX_ERR_OUT, ALIGN_IDX_SEL});
  assign pv[2] = 32'(CORE_RX_WORD);
  assign pv[3] = 32'(SER_TX_WORD);
  assign pv[4] = 32'({TX_LPI_REFRESH_TIME, TX_LPI_QUIET_TIME, TX_LPI_SLEEP_TIME, NON_EEE_COMPAT});
  assign pv[5] = 32'({IRQ, AN_COMPLETE, SERIAL_EN, AN_ENABLE});
  // ------------------------------------------------------------
  // Checking and reporting
  // ------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Oldest note meets the result as it appears
  always @(posedge REF_CLK)
  begin
    if ((rd_ph && HREADYOUT) || smp)
    begin
      n = q.pop_front();
      cmp(n.nm, smp ? pv[psel] : HRDATA, n.e);
    end
  end
  // ------------------------------------------------------------
  // Bus master and probe drivers
  // ------------------------------------------------------------
  task automatic tk(input int c);
    repeat (c) @(posedge REF_CLK);
  endtask : tk

  // Word in plain or reversed bit order
  function automatic logic [9:0] ord10(input logic [9:0] x, input logic f);
    ord10 = x;
    if (f)
      ord10 = {<<{x}};
  endfunction : ord10

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] d);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {18'h0, idx, 2'b00};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rd_ph <= !wr;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd_ph <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] idx, input logic [31:0] e, input string nm);
    q.push_back('{nm, e});
    bus(idx, 1'b0, '0);
  endtask : rd

  task automatic pchk(input logic [2:0] s, input logic [31:0] e, input string nm);
    q.push_back('{nm, e});
    psel <= s;
    smp <= 1'b1;
    @(posedge REF_CLK);
    smp <= 1'b0;
    @(posedge REF_CLK);
  endtask : pchk
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(4721));
    tk(3);
    RST_N <= 1'b1;
    tk(3);
    rd(serial_if_regs_pkg::IDX_CTRL_ONE, 32'h027b, "ctrl_rst");
    rd(serial_if_regs_pkg::IDX_LPI_TMR, 32'h0, "lpi_rst");
    rd(serial_if_regs_pkg::IDX_STATUS, 32'h0, "status_rst");
    pchk(5, 32'h3, "flags_rst");
    bus(serial_if_regs_pkg::IDX_WAKE, 1'b1, 32'hffff);
    rd(serial_if_regs_pkg::IDX_WAKE, 32'h3, "wake_rsvd");
    bus(12'h604, 1'b1, 32'hffff);
    rd(12'h604, 32'h0, "unmapped");
    // Wake codes only from the supported set
    LPI_EXIT <= 1'b1;
    for (int c = 1; c < 4; c++)
    begin
      bus(serial_if_regs_pkg::IDX_WAKE, 1'b1, 32'(c));
      tk(3);
      pchk(0, {c[1], c[0] ? 4'h0 : 4'h1}, "wake_rx");
    end
    LPI_EXIT <= 1'b0;
    LPI_IDLE <= 1'b1;
    tk(3);
    pchk(0, 32'h01, "idle_rx");
    LPI_IDLE <= 1'b0;
    // Eight random control words with serial enable set; order, polarity and align bits drawn at random
    for (int i = 0; i < 8; i++)
    begin
      r = ($urandom & 32'hffff) | 32'h0200;
      bus(serial_if_regs_pkg::IDX_CTRL_ONE, 1'b1, r);
      step <= 1'b1;
      {TX_PKT_START_REQ, TX_EVEN} <= 2'($urandom);
      tk(1);
      step <= 1'b0;
      tk(3);
      rd(serial_if_regs_pkg::IDX_CTRL_ONE, r, "ctrl_rw");
      pk = {r[3] ? TX_PKT_START_REQ & TX_EVEN : TX_PKT_START_REQ, TX_ERR_IN & ~r[15]};
      pchk(1, {pk, r[14] ? r[13:10] : ALIGN_IDX_FOUND}, "err_idx");
      pchk(2, ord10(SER_RX_WORD ^ {10{r[8]}}, r[5]), "rx_word");
      pchk(3, ord10(CORE_TX_WORD, r[4]) ^ {10{r[7]}}, "tx_word");
    end
    r = $urandom & 32'hffff;
    bus(serial_if_regs_pkg::IDX_LPI_TMR, 1'b1, r);
    rd(serial_if_regs_pkg::IDX_LPI_TMR, r, "lpi_rw");
    pchk(4, r, "lpi_out");
    // Every timer code, restarted by a disable first
    AN_LINK_OK <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      bus(serial_if_regs_pkg::IDX_CTRL_ONE, 1'b1, 32'h0200);
      bus(serial_if_regs_pkg::IDX_CTRL_ONE, 1'b1, 32'h0201 | (c << 1));
      for (k = 0; k < 200 && AN_COMPLETE !== 1'b1; k++) @(negedge REF_CLK);
      cmp("an_time", 32'(k >= lim[c] && k <= lim[c] + 3), 32'h1);
      rd(serial_if_regs_pkg::IDX_STATUS, 32'h0400, "an_done");
    end
    // Completion event raised, masked, unmasked and cleared
    rd(serial_if_regs_pkg::IDX_INT_STATUS, 32'h2, "int_done");
    pchk(5, 32'h7, "irq_masked");
    bus(serial_if_regs_pkg::IDX_INT_MASK, 1'b1, 32'h3);
    tk(2);
    pchk(5, 32'hf, "irq_on");
    bus(serial_if_regs_pkg::IDX_INT_STATUS, 1'b1, 32'h2);
    tk(2);
    pchk(5, 32'h7, "irq_off");
    AN_PAGE_RX <= 1'b1;
    tk(1);
    AN_PAGE_RX <= 1'b0;
    tk(2);
    rd(serial_if_regs_pkg::IDX_STATUS, 32'h1400, "page");
    rd(serial_if_regs_pkg::IDX_STATUS, 32'h0400, "page_clr");
    rd(serial_if_regs_pkg::IDX_INT_STATUS, 32'h1, "int_page");
    pchk(5, 32'hf, "irq_page");
    // Second reset with straps set: serial side must come up off
    strap <= 1'b1;
    RST_N <= 1'b0;
    tk(2);
    RST_N <= 1'b1;
    tk(3);
    rd(serial_if_regs_pkg::IDX_CTRL_ONE, 32'h007b, "ctrl_strap");
    pchk(5, 32'h1, "flags_strap");
    pchk(2, 32'h0, "rx_off");
    test_done();
  end

  // Run needs under five hundred cycles; the 20000-cycle limit means a hang
  initial
  begin
    #2000000;
    fails++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
